/* File: src/wake_pkg.sv */
// Package for the periodic wake-up timer and trim register block.
// Assumes a single bus clock domain and an APB slave with 32-bit data.
package wake_pkg;

  // Printed offsets are not all multiples of four, so each is kept as an index.
  localparam logic [7:0] IDX_CTRL       = 8'h10;
  localparam logic [7:0] IDX_RATE_HIGH  = 8'h12;
  localparam logic [7:0] IDX_RATE_LOW   = 8'h13;
  localparam logic [7:0] IDX_TEST       = 8'h14;
  localparam logic [7:0] IDX_HOT_TRIM   = 8'h15;
  localparam logic [7:0] IDX_REF_HIGH   = 8'h18;
  localparam logic [7:0] IDX_REF_LOW    = 8'h19;
  localparam logic [7:0] IDX_STATUS     = 8'h1C;
  localparam logic [7:0] IDX_MASK       = 8'h1D;

  // Control register fields.
  localparam int CTRL_CLK_SEL_BIT = 7;
  localparam int CTRL_FE_BIT      = 2;
  localparam int CTRL_IE_BIT      = 1;
  localparam int CTRL_FLAG_BIT    = 0;

  // Hot trim fields.
  localparam int HOT_OE_BIT = 7;

  // Status and mask bit positions.
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_LOCKLOSS_BIT = 1;
  localparam int ST_W = 2;

  // Reference trim field positions.
  localparam int TC_HI = 15;
  localparam int TC_LO = 11;
  localparam int FT_HI = 9;
  localparam int FT_LO = 0;

  // Reset values.
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_REF_TRIM = 16'h0000;

  // Number of extra RC cycles added at first time-out after enable.
  localparam logic [1:0] FIRST_EXTRA_RC = 2'h2;

  // Bus access carried from decode to register file.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } reg_access_s;

  // Trim outputs toward the analog side.
  typedef struct packed {
    logic [4:0] temp_coeff_trim;
    logic [9:0] ref_freq_trim;
  } ref_trim_s;

endpackage : wake_pkg

/* File: src/rc_edge_tick.sv */
// One-cycle tick on each rising edge of the sampled RC clock level.
// Assumes rc_clk_level is synchronous to pclk.
module rc_edge_tick
  import wake_pkg::*;
(
  input  wire logic pclk,          // Bus clock.
  input  wire logic presetn,       // Asynchronous reset, active low.
  input  wire logic rc_clk_level,  // Sampled RC clock level.
  output logic      tick           // Pulse on RC rising edge.
);

  logic prev_reg;

  // Remember previous level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= rc_clk_level;
    end
  end

  assign tick = rc_clk_level & ~prev_reg;

endmodule : rc_edge_tick

/* File: src/trim_loader.sv */
// Flags one load of the flash trim value after reset release.
// Assumes flash_valid rises once the flash trim word is present.
module trim_loader
  import wake_pkg::*;
(
  input  wire logic        pclk,        // Bus clock.
  input  wire logic        presetn,     // Asynchronous reset, active low.
  input  wire logic        flash_valid, // Flash trim word valid.
  output logic             load_pulse   // One-cycle load request.
);

  logic done_reg;

  // Fires once, at the first cycle after release with valid flash data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (flash_valid) begin
      done_reg <= 1'b1;
    end
  end

  assign load_pulse = flash_valid & ~done_reg;

endmodule : trim_loader

/* File: src/periodic_wakeup_top.sv */
// Periodic wake-up timer, rate, factory test, hot trim and reference trim registers.
// Assumes an APB master on pclk, a sampled RC clock level and a flash trim word.

// Notes on behaviour
// - The 16-bit rate sits in a high and a low byte that ignore writes while the timer is enabled.
// - With the RC clock the period is 2*(rate+1) times two RC periods.
// - With the bus clock the period is 2*(rate+1) bus cycles.
// - With the RC clock the first period after enable holds two more RC edges than the later ones.
// - The factory test register always reads and is written only in special mode.
// - Bit 7 of the hot trim register enables the offset, otherwise the trim code has no effect.
// - The 4-bit hot trim code is passed straight and monotonic to the sensor.
// - The reference trim bytes at 0x18 and 0x19 are written only while protection is clear.
// - A reference trim write while the PLL is selected clears lock and oscillator-up status.
// - After reset release the reference trim is loaded from the flash trim word.
// - Bits 15 to 11 of the reference trim hold the temperature coefficient trim.
// - Bits 9 to 0 hold the frequency trim, four coarse and six fine bits.
// - The clock select bit picks RC (0) or bus clock (1) and is writable only while disabled.
// - The feature enable starts the timer and holding it clear keeps it stopped.
// - Time-out sets a flag cleared by writing one, and it requests an interrupt when enabled.
module periodic_wakeup_top
  import wake_pkg::*;
(
  input  wire logic        pclk,            // Bus clock.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB direction.
  input  wire logic [11:0] paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic             pready,          // APB ready.
  output logic [31:0]      prdata,          // APB read data.
  output logic             pslverr,         // APB error on unmapped address.
  input  wire logic        rc_clk_level,    // Sampled RC clock level.
  input  wire logic        special_mode,    // Factory special mode.
  input  wire logic        reg_protect_bit, // Register protection.
  input  wire logic        pll_clock_select,// PLL selected as clock.
  input  wire logic        flash_valid,     // Flash trim word ready.
  input  wire logic [15:0] flash_trim,      // Flash trim word.
  output logic             irq,             // Level interrupt.
  output logic             periodic_irq_req,// Time-out flag and enable.
  output logic             clear_lock_osc,  // Pulse: clear lock and osc-up.
  output logic [3:0]       hot_trim_code,   // Sensor trim code.
  output logic             hot_offset_enable,// Sensor offset enable.
  output logic [7:0]       factory_test_out,// Factory test bits.
  output ref_trim_s        ref_trim         // Reference oscillator trim.
);

  // Register state.
  logic [7:0]      ctrl_reg;
  logic [15:0]     rate_reg;
  logic [7:0]      test_reg;
  logic [7:0]      hot_reg;
  logic [15:0]     ref_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic [17:0]     count_reg;
  logic [1:0]      first_reg;
  logic            rc_half_reg;

  // Bus decode.
  reg_access_s acc;
  wire         setup_ok = psel & ~penable;
  assign acc.wr    = psel & penable & pwrite;
  assign acc.rd    = psel & penable & ~pwrite;
  assign acc.idx   = paddr[9:2];
  assign acc.wdata = pwdata[7:0];

  wire hit_ctrl  = acc.idx == IDX_CTRL;
  wire hit_rh    = acc.idx == IDX_RATE_HIGH;
  wire hit_rl    = acc.idx == IDX_RATE_LOW;
  wire hit_test  = acc.idx == IDX_TEST;
  wire hit_hot   = acc.idx == IDX_HOT_TRIM;
  wire hit_refh  = acc.idx == IDX_REF_HIGH;
  wire hit_refl  = acc.idx == IDX_REF_LOW;
  wire hit_st    = acc.idx == IDX_STATUS;
  wire hit_mask  = acc.idx == IDX_MASK;
  wire mapped    = hit_ctrl | hit_rh | hit_rl | hit_test | hit_hot | hit_refh | hit_refl
                   | hit_st | hit_mask;
  wire addr_ok   = mapped & (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0);

  wire fe        = ctrl_reg[CTRL_FE_BIT];
  wire clk_bus   = ctrl_reg[CTRL_CLK_SEL_BIT];

  // Write strobes per register.
  wire wr_ctrl   = acc.wr & addr_ok & hit_ctrl;
  wire wr_rate_h = acc.wr & addr_ok & hit_rh & ~fe;
  wire wr_rate_l = acc.wr & addr_ok & hit_rl & ~fe;
  wire wr_test   = acc.wr & addr_ok & hit_test & special_mode;
  wire wr_hot    = acc.wr & addr_ok & hit_hot;
  wire wr_ref_h  = acc.wr & addr_ok & hit_refh & ~reg_protect_bit;
  wire wr_ref_l  = acc.wr & addr_ok & hit_refl & ~reg_protect_bit;
  wire wr_st     = acc.wr & addr_ok & hit_st;
  wire wr_mask   = acc.wr & addr_ok & hit_mask;
  wire ref_wr    = wr_ref_h | wr_ref_l;

  // RC and flash helpers.
  logic rc_tick;
  logic load_pulse;

  rc_edge_tick u_rc_tick (
    .pclk         (pclk),
    .presetn      (presetn),
    .rc_clk_level (rc_clk_level),
    .tick         (rc_tick)
  );

  trim_loader u_loader (
    .pclk        (pclk),
    .presetn     (presetn),
    .flash_valid (flash_valid),
    .load_pulse  (load_pulse)
  );

  // Timer step: bus clock counts every cycle, RC counts every second RC edge.
  wire rc_step   = rc_tick & rc_half_reg;
  wire step      = fe & (clk_bus ? 1'b1 : (rc_step & (first_reg == 2'h0)));
  wire [17:0] period_m1 = {1'b0, rate_reg, 1'b1};                    // 2*(rate+1)-1
  wire timeout   = step & (count_reg == period_m1);

  // Control bits; clock select only changes while disabled before this write.
  wire clk_bus_next = fe ? clk_bus : acc.wdata[CTRL_CLK_SEL_BIT];
  wire [7:0] ctrl_next = {clk_bus_next, ctrl_reg[6:3], acc.wdata[CTRL_FE_BIT],
                          acc.wdata[CTRL_IE_BIT], 1'b0};

  // Flag clear: write one to status bit or control flag bit.
  wire clr_to    = (wr_st & acc.wdata[ST_TIMEOUT_BIT]) | (wr_ctrl & acc.wdata[CTRL_FLAG_BIT]);
  wire clr_ll    = wr_st & acc.wdata[ST_LOCKLOSS_BIT];
  wire lockloss  = ref_wr & pll_clock_select;
  wire [ST_W-1:0] status_next = {lockloss | (status_reg[1] & ~clr_ll),
                                 timeout | (status_reg[0] & ~clr_to)};

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= RST_BYTE;
      rate_reg <= {RST_BYTE, RST_BYTE};
      test_reg <= RST_BYTE;
      hot_reg  <= RST_BYTE;
      mask_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_next;
      if (wr_rate_h) rate_reg[15:8] <= acc.wdata;
      if (wr_rate_l) rate_reg[7:0] <= acc.wdata;
      if (wr_test) test_reg <= acc.wdata;
      if (wr_hot) hot_reg <= acc.wdata;
      if (wr_mask) mask_reg <= acc.wdata[ST_W-1:0];
    end
  end

  // Reference trim: flash load after reset, else protected bus writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_reg <= RST_REF_TRIM;
    end else if (load_pulse) begin
      ref_reg <= flash_trim;
    end else begin
      if (wr_ref_h) ref_reg[15:8] <= acc.wdata;
      if (wr_ref_l) ref_reg[7:0] <= acc.wdata;
    end
  end

  // Period counter with first-period gate delay on RC clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg   <= '0;
      first_reg   <= 2'h0;
      rc_half_reg <= 1'b0;
    end else if (!fe) begin
      count_reg   <= '0;
      first_reg   <= FIRST_EXTRA_RC;
      rc_half_reg <= 1'b0;
    end else begin
      if (rc_tick && first_reg != 2'h0) begin
        first_reg <= first_reg - 2'h1;
      end else if (rc_tick) begin
        rc_half_reg <= ~rc_half_reg;
      end
      if (clk_bus) first_reg <= 2'h0;
      if (timeout) begin
        count_reg <= '0;
      end else if (step) begin
        count_reg <= count_reg + 18'h1;
      end
    end
  end

  // Status register and outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg        <= '0;
      irq               <= 1'b0;
      periodic_irq_req  <= 1'b0;
      clear_lock_osc    <= 1'b0;
      hot_trim_code     <= 4'h0;
      hot_offset_enable <= 1'b0;
      factory_test_out  <= RST_BYTE;
      ref_trim          <= '0;
    end else begin
      status_reg        <= status_next;
      irq               <= |(status_next & mask_reg);
      periodic_irq_req  <= status_next[ST_TIMEOUT_BIT] & ctrl_reg[CTRL_IE_BIT];
      clear_lock_osc    <= lockloss;
      hot_offset_enable <= hot_reg[HOT_OE_BIT];
      hot_trim_code     <= hot_reg[HOT_OE_BIT] ? hot_reg[3:0] : 4'h0;
      factory_test_out  <= test_reg;
      ref_trim.temp_coeff_trim <= ref_reg[TC_HI:TC_LO];
      ref_trim.ref_freq_trim   <= ref_reg[FT_HI:FT_LO];
    end
  end

  // Read mux.
  logic [7:0] rd_byte;
  assign rd_byte = hit_ctrl ? {ctrl_reg[7:1], status_reg[ST_TIMEOUT_BIT]} :
                   hit_rh   ? rate_reg[15:8] :
                   hit_rl   ? rate_reg[7:0] :
                   hit_test ? test_reg :
                   hit_hot  ? {hot_reg[7], 3'h0, hot_reg[3:0]} :
                   hit_refh ? ref_reg[15:8] :
                   hit_refl ? ref_reg[7:0] :
                   hit_st   ? {6'h00, status_reg} :
                   hit_mask ? {6'h00, mask_reg} : 8'h00;

  // APB answer: no wait states, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ok;
      prdata  <= (setup_ok & ~pwrite & addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr <= setup_ok & ~addr_ok;
    end
  end

  // Bus cycles since enable or the last time-out, counted apart from the timer itself.
  logic [17:0] gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= '0;
    end else if (!fe || timeout) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + 18'h1;
    end
  end

  // RC rising edges since enable or the last time-out; one spare bit covers the first period.
  logic [18:0] rc_gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_gap_reg <= '0;
    end else if (!fe || timeout) begin
      rc_gap_reg <= '0;
    end else if (rc_tick) begin
      rc_gap_reg <= rc_gap_reg + 19'h1;
    end
  end

  // Assertions on the rate lock, the periods, the flag and the protected registers.
  property p_rate_locked;
    @(posedge pclk) disable iff (!presetn)
      fe && $past(fe) |-> $stable(rate_reg);
  endproperty
  a_rate_locked: assert property (p_rate_locked) else $error("Rate moved while enabled");

  property p_bus_period;
    @(posedge pclk) disable iff (!presetn)
      timeout && clk_bus |-> gap_reg == {1'b0, rate_reg, 1'b1};
  endproperty
  a_bus_period: assert property (p_bus_period) else $error("Bus period mismatch");

  // Four RC edges per rate step; the first period after enable holds two more.
  property p_rc_period;
    @(posedge pclk) disable iff (!presetn)
      timeout && !clk_bus |-> rc_gap_reg == {1'b0, rate_reg, 2'b11}
                              || rc_gap_reg == {1'b0, rate_reg, 2'b11} + 19'h2;
  endproperty
  a_rc_period: assert property (p_rc_period) else $error("RC period mismatch");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn) clr_to && !timeout |=> !status_reg[ST_TIMEOUT_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      status_reg[ST_TIMEOUT_BIT] && !clr_to |=> status_reg[ST_TIMEOUT_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag lost without a clear");

  property p_irq_masked;
    @(posedge pclk) disable iff (!presetn) !(|mask_reg) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("Interrupt while masked");

  property p_clk_sel_lock;
    @(posedge pclk) disable iff (!presetn) fe |=> $stable(clk_bus);
  endproperty
  a_clk_sel_lock: assert property (p_clk_sel_lock) else $error("Source moved");

  property p_hot_off;
    @(posedge pclk) disable iff (!presetn)
      !hot_reg[HOT_OE_BIT] |=> hot_trim_code == 4'h0 && !hot_offset_enable;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("Hot trim active while off");

  property p_hot_code;
    @(posedge pclk) disable iff (!presetn)
      hot_reg[HOT_OE_BIT] |=> hot_trim_code == $past(hot_reg[3:0]);
  endproperty
  a_hot_code: assert property (p_hot_code) else $error("Hot trim code altered");

  property p_load;
    @(posedge pclk) disable iff (!presetn) load_pulse |=> ref_reg == $past(flash_trim);
  endproperty
  a_load: assert property (p_load) else $error("Flash trim not loaded");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) timeout |=> status_reg[ST_TIMEOUT_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag not set on time-out");

  property p_restart;
    @(posedge pclk) disable iff (!presetn) timeout |=> count_reg == 18'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("Count not restarted");

  property p_stopped;
    @(posedge pclk) disable iff (!presetn) !fe |=> !timeout;
  endproperty
  a_stopped: assert property (p_stopped) else $error("Time-out while disabled");

  property p_reg_protect_bit;
    @(posedge pclk) disable iff (!presetn)
      reg_protect_bit && !load_pulse |=> $stable(ref_reg);
  endproperty
  a_reg_protect_bit: assert property (p_reg_protect_bit) else $error("Protected trim changed");

  property p_lockclr;
    @(posedge pclk) disable iff (!presetn) ref_wr && pll_clock_select |=> clear_lock_osc;
  endproperty
  a_lockclr: assert property (p_lockclr) else $error("Lock clear missing");

  property p_test_wr;
    @(posedge pclk) disable iff (!presetn) !special_mode |=> $stable(test_reg);
  endproperty
  a_test_wr: assert property (p_test_wr) else $error("Test register written");

  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) timeout && !clk_bus);
  c_irq:     cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_load:    cover property (@(posedge pclk) disable iff (!presetn) load_pulse);
  c_locked:  cover property (@(posedge pclk) disable iff (!presetn) wr_rate_h == 1'b0
                             && acc.wr && addr_ok && hit_rh && fe);
  c_clear:   cover property (@(posedge pclk) disable iff (!presetn)
                             clr_to && status_reg[ST_TIMEOUT_BIT]);

endmodule : periodic_wakeup_top

/* File: testbench/periodic_wakeup_rate_and_trim_regs_test.sv */
// Self-checking bench for the periodic wake-up timer and trim register block.
// Assumes an APB slave answering with pready and a free-running sampled RC level.
module periodic_wakeup_rate_and_trim_regs_test
  import wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %0h want %0h", $time, (a), (b)); end end

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        special_mode, reg_protect_bit, pll_clock_select, flash_valid;
  logic        rc_clk_level = 1'b0;
  logic [15:0] flash_trim;
  logic        irq, periodic_irq_req, clear_lock_osc, hot_offset_enable, er;
  logic        req_d = 1'b0;
  logic [3:0]  hot_trim_code;
  logic [7:0]  factory_test_out;
  logic [1:0]  rc_div = 2'h0;
  ref_trim_s   ref_trim;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n_rise = 0;
  int          t_rise = 0;
  int          t_prev = 0;
  int          n_clr = 0;

  periodic_wakeup_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rc_clk_level(rc_clk_level), .special_mode(special_mode),
    .reg_protect_bit(reg_protect_bit), .pll_clock_select(pll_clock_select),
    .flash_valid(flash_valid), .flash_trim(flash_trim), .irq(irq),
    .periodic_irq_req(periodic_irq_req), .clear_lock_osc(clear_lock_osc),
    .hot_trim_code(hot_trim_code), .hot_offset_enable(hot_offset_enable),
    .factory_test_out(factory_test_out), .ref_trim(ref_trim)
  );

  // Bus clock of 40 ns.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // RC level toggles every two bus cycles, so one RC period is four bus cycles.
  always @(posedge pclk) begin
    rc_div <= rc_div + 2'h1;
    if (rc_div[0]) rc_clk_level <= ~rc_clk_level;
  end

  // Records the cycle of each rising request and counts lock-clear pulses.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    req_d <= periodic_irq_req;
    if (periodic_irq_req === 1'b1 && req_d !== 1'b1) begin
      n_rise <= n_rise + 1;
      t_prev <= t_rise;
      t_rise <= cyc;
    end
    if (clear_lock_osc === 1'b1) n_clr <= n_clr + 1;
  end

  // One APB transfer, entered just after a rising edge, followed by one idle cycle.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // The access phase lasts until ready; only the watchdog ends a hung wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus

  // Reads one register and compares its low byte.
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(rd[7:0], exp)
  endtask : rdc

  // Waits, bounded, until the count of rising requests reaches n.
  task automatic wait_rise(input int n);
    int k;
    k = 0;
    while (n_rise < n && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      $display("BAD %0t no time-out", $time);
    end
  endtask : wait_rise

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end

  // Main sequence.
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h00000000; special_mode = 1'b0;
    reg_protect_bit = 1'b1; pll_clock_select = 1'b0; flash_valid = 1'b0;
    flash_trim = 16'hA1C3;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(ref_trim, 15'h0000)
    flash_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(ref_trim, {5'h14, 10'h1C3})
    rdc(IDX_REF_HIGH, 8'hA1);
    rdc(IDX_REF_LOW, 8'hC3);
    bus(1'b1, IDX_REF_HIGH, 8'hFF);
    rdc(IDX_REF_HIGH, 8'hA1);
    reg_protect_bit <= 1'b0;
    pll_clock_select <= 1'b1;
    bus(1'b1, IDX_REF_LOW, 8'h3C);
    repeat (2) @(posedge pclk);
    `CHK(ref_trim, {5'h14, 10'h13C})
    `CHK(n_clr, 1)
    pll_clock_select <= 1'b0;
    bus(1'b1, IDX_REF_HIGH, 8'h08);
    repeat (2) @(posedge pclk);
    `CHK(ref_trim, {5'h01, 10'h03C})
    `CHK(n_clr, 1)
    // Every hot trim code reaches the sensor unchanged while the offset is on.
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, IDX_HOT_TRIM, {4'h8, c[3:0]});
      @(posedge pclk);
      `CHK({hot_offset_enable, hot_trim_code}, {1'b1, c[3:0]})
    end
    bus(1'b1, IDX_HOT_TRIM, 8'h0A);
    @(posedge pclk);
    `CHK({hot_offset_enable, hot_trim_code}, 5'h00)
    bus(1'b1, IDX_TEST, 8'h5A);
    rdc(IDX_TEST, 8'h00);
    special_mode <= 1'b1;
    bus(1'b1, IDX_TEST, 8'h5A);
    rdc(IDX_TEST, 8'h5A);
    `CHK(factory_test_out, 8'h5A)
    bus(1'b0, 8'h3F, 8'h00);
    `CHK({er, rd}, {1'b1, 32'h00000000})
    // Bus-clock source, rate 5: period of 12 cycles.
    bus(1'b1, IDX_RATE_HIGH, 8'h00);
    bus(1'b1, IDX_RATE_LOW, 8'h05);
    bus(1'b1, IDX_CTRL, 8'h86);
    wait_rise(1);
    bus(1'b1, IDX_CTRL, 8'h06);
    rdc(IDX_CTRL, 8'h87);
    bus(1'b1, IDX_RATE_LOW, 8'h77);
    bus(1'b1, IDX_RATE_HIGH, 8'h12);
    rdc(IDX_RATE_LOW, 8'h05);
    rdc(IDX_RATE_HIGH, 8'h00);
    `CHK(irq, 1'b0)
    bus(1'b1, IDX_CTRL, 8'h87);
    wait_rise(2);
    bus(1'b1, IDX_CTRL, 8'h87);
    wait_rise(3);
    `CHK(t_rise - t_prev, 12)
    `CHK(periodic_irq_req, 1'b1)
    // Disable and keep the flag; the earlier trim write left lock-loss set too.
    bus(1'b1, IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 8'h81);
    rdc(IDX_STATUS, 8'h03);
    bus(1'b1, IDX_MASK, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    bus(1'b1, IDX_STATUS, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    // A stopped timer must not set the freshly cleared flag again.
    repeat (40) @(posedge pclk);
    `CHK(n_rise, 3)
    rdc(IDX_STATUS, 8'h02);
    // RC source, rate 0: 2 x 1 x 2 RC periods of 4 cycles = 16 cycles.
    bus(1'b1, IDX_CTRL, 8'h00);
    bus(1'b1, IDX_RATE_LOW, 8'h00);
    rdc(IDX_RATE_LOW, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h06);
    wait_rise(4);
    bus(1'b1, IDX_CTRL, 8'h07);
    wait_rise(5);
    bus(1'b1, IDX_CTRL, 8'h07);
    wait_rise(6);
    `CHK(t_rise - t_prev, 16)
    rdc(IDX_CTRL, 8'h07);
    close_out();
  end

endmodule : periodic_wakeup_rate_and_trim_regs_test
